//--- rtl/ccc_cfg.svh
/*
  Offsets, field positions, reset values and timing counts of the charge
  cycle controller. Assumes it is included by its bare name.
*/
`ifndef CCC_CFG_SVH
`define CCC_CFG_SVH
// Register byte addresses.
`define CCC_OFS_CTRL 8'h00
`define CCC_OFS_VOLT 8'h04
`define CCC_OFS_IFAST 8'h08
`define CCC_OFS_ILOW 8'h0c
`define CCC_OFS_TEMP 8'h10
`define CCC_OFS_STAT 8'h14
`define CCC_OFS_ZFLAG 8'h18
// Control register fields.
`define CCC_CTRL_ALLOW 0
`define CCC_CTRL_TERM 1
`define CCC_CTRL_TOPOFF_LO 2
`define CCC_CTRL_TOPOFF_HI 3
`define CCC_CTRL_RST 4
`define CCC_CTRL_BYPASS 5
`define CCC_CTRL_CONVOFF 6
`define CCC_CTRL_SUPPRESS 7
// Reset values.
`define CCC_RST_CTRL 8'h03
`define CCC_RST_REGULATION_VOLTAGE_MV 16'h1068
`define CCC_RST_RECHG_MV 16'h0064
`define CCC_RST_FAST_CHARGE_CURRENT_MA 16'h0140
`define CCC_RST_TERMINATION_CURRENT_MA 16'h0014
`define CCC_RST_ITRK_MA 16'h000a
`define CCC_RST_IPRE_MA 16'h001e
`define CCC_RST_TEMP 14'h1b7b
// Timer limits in minutes.
`define CCC_TRICKLE_MIN 10'h03c
`define CCC_TOPOFF_STEP_MIN 6'h0f
// Seconds in one minute, counted in base ticks.
`define CCC_TICKS_PER_MIN 6'h3c
`endif

//--- rtl/ccc_pkg.sv
/*
  Types of the charge cycle controller. Assumes ccc_cfg.svh is on the path.
*/
package ccc_pkg;
  // Cycle states, one-hot.
  typedef enum logic [3:0] {
    CCC_IDLE = 4'b0001,
    CCC_CHARGE = 4'b0010,
    CCC_TOPOFF = 4'b0100,
    CCC_DONE = 4'b1000
  } ccc_state_t;
  // Reported charge phase codes.
  typedef enum logic [1:0] {
    CCC_PH_OFF = 2'b00,
    CCC_PH_CC = 2'b01,
    CCC_PH_CV = 2'b10,
    CCC_PH_TOP = 2'b11
  } ccc_phase_t;
endpackage

//--- rtl/ccc_top.sv
/*
  Charge cycle controller: cycle sequencing, top-off timer, thermistor zone
  qualification, current fold-back and an APB register slave.
  Assumes all analog indications are synchronous to pclk and that tick_1hz
  is a one-cycle pulse once per second from the device timebase.
*/
// What this block does
// RL1: Charge autonomously when bit set, pin low.
// RL2: Settings reset to documented charge defaults.
// RL3: Start needs converter, enables, no faults.
// RL4: Terminate on CV, low current, above threshold.
// RL5: Recharge when done battery drops below threshold.
// RL6: Enable toggle after termination restarts charging.
// RL7: Phase field codes off, CC, CV, top-off.
// RL8: Battery switch off when done, supplement allowed.
// RL9: Termination allow cleared means never terminate.
// RL10: Top-off timer follows safety pause, half rate.
// RL11: Top-off timer resets on stop, entry, reset.
// RL12: Top-off duration latched at termination.
// RL13: Event flag on top-off entry and expiry.
// RL14: Bypass makes temperature valid, zone 000.
// RL15: Bypass forces conversion-off bit to one.
// RL16: Zone change updates field, flag, pulse.
// RL17: Reduced fold-back makes safety timer half rate.
// RL18: Temperature suspend pauses timer, blinks, phase 00.
// RL19: Codes 00 suspend, 11 unchanged, rate ignored.
// RL20: Codes 01, 10 divided by C-rate.
// RL21: Bias switch closed only during measurement.
// RL22: Bias short opens switch, zone 3, suspends.
// RL23: Trickle timer one hour, others programmable.
// RL24: Analog indications registered on device clock.
`timescale 1ns/1ps
`include "ccc_cfg.svh"
module ccc_top
  import ccc_pkg::*;
(
  // Clock, reset, enable.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins and analog indications.
  input wire logic charge_enable_pin_n,
  input wire logic converter_running,
  input wire logic cv_loop_active,
  input wire logic input_current_loop,
  input wire logic input_voltage_loop,
  input wire logic thermal_loop_active,
  input wire logic vbat_above_rechg,
  input wire logic ibat_below_term,
  input wire logic [2:0] zone_in,
  input wire logic bias_short,
  input wire logic meas_request,
  input wire logic safety_fault,
  input wire logic safety_pause_in,
  input wire logic safety_half_in,
  input wire logic supplement_req,
  input wire logic [1:0] battery_stage,
  input wire logic tick_1hz,
  // Controls toward the analog side and the safety timers.
  output logic [1:0] charge_phase_field,
  output logic charging_active,
  output logic battery_switch,
  output logic thermistor_bias_output,
  output logic stat_o,
  output logic stat_oe,
  output logic temp_int_pulse,
  output logic safety_pause,
  output logic safety_half_rate,
  output logic [15:0] charge_current_ma,
  output logic [9:0] safety_limit_min
);
  ccc_state_t state_reg, state_next;
  logic [7:0] ctrl_reg;
  logic [15:0] regulation_voltage_reg, rechg_reg, fast_charge_current_reg, termination_current_reg, itrk_reg, ipre_reg;
  logic [13:0] temp_reg;
  logic [7:0] zflag_reg;
  logic [2:0] zone_reg, zone_field_reg, znew;
  logic flag_reg, blink_reg, half_tick_reg;
  logic cv_s, iin_s, vin_s, thr_s, above_s, below_s, short_s, meas_s, pin_n_s, conv_s;
  logic fault_s, spause_s, shalf_s, supp_s, tick_s;
  logic [1:0] stage_s;
  logic [1:0] topoff_dur_reg;
  logic [9:0] topoff_min_reg;
  logic [5:0] topoff_sec_reg;
  logic wr, rd, enable, suspend, therm_fault, start_ok, term_ok, half, pause;
  logic topoff_expire, topoff_clr;
  logic [1:0] zcode;
  logic [15:0] fold_ma;

  // Every analog indication passes one flop so the logic sees clean levels.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      {cv_s, iin_s, vin_s, thr_s, above_s, below_s, short_s, meas_s} <= 8'h00;
      {pin_n_s, conv_s, fault_s, spause_s, shalf_s, supp_s, tick_s} <= 7'h40;
      stage_s <= 2'h0;
      zone_reg <= 3'h0;
    end
    else if (clk_en)
    begin
      {cv_s, iin_s, vin_s, thr_s} <= {cv_loop_active, input_current_loop,
        input_voltage_loop, thermal_loop_active}; // RL24
      {above_s, below_s, short_s, meas_s} <= {vbat_above_rechg, ibat_below_term,
        bias_short, meas_request};
      {pin_n_s, conv_s, fault_s} <= {charge_enable_pin_n, converter_running, safety_fault};
      {spause_s, shalf_s, supp_s, tick_s} <= {safety_pause_in, safety_half_in,
        supplement_req, tick_1hz};
      stage_s <= battery_stage;
      zone_reg <= zone_in;
    end
  end

  // Bus strobes: the access phase completes one cycle after setup.
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && penable && pready && !pwrite;

  // Temperature qualification; bypass makes every zone valid.
  assign zcode = (zone_reg == 3'h5) ? temp_reg[1:0] : (zone_reg == 3'h4) ? temp_reg[3:2] :
    (zone_reg == 3'h2) ? temp_reg[5:4] : (zone_reg == 3'h1) ? temp_reg[7:6] : 2'h3;
  assign therm_fault = !ctrl_reg[`CCC_CTRL_BYPASS] &&
    (short_s || zone_reg == 3'h6 || zone_reg == 3'h7); // RL14 RL22
  assign suspend = therm_fault || (!ctrl_reg[`CCC_CTRL_BYPASS] && zcode == 2'h0); // RL19
  assign enable = ctrl_reg[`CCC_CTRL_ALLOW] && !pin_n_s; // RL1
  assign start_ok = conv_s && enable && !therm_fault && !fault_s; // RL3
  assign term_ok = above_s && cv_s && below_s && !iin_s && !vin_s && !thr_s &&
    ctrl_reg[`CCC_CTRL_TERM] && !suspend; // RL4 RL9
  assign half = shalf_s || (!ctrl_reg[`CCC_CTRL_BYPASS] && (zcode == 2'h1 || zcode == 2'h2));
  assign pause = spause_s || suspend;
  assign znew = ctrl_reg[`CCC_CTRL_BYPASS] ? 3'h0 : short_s ? 3'h3 : zone_reg; // RL14 RL22
  assign topoff_expire = state_reg == CCC_TOPOFF && topoff_sec_reg == 6'h00 &&
    topoff_min_reg == 10'(topoff_dur_reg) * 10'(`CCC_TOPOFF_STEP_MIN);

  // Cycle sequencing; dropping either enable or the converter stops the cycle.
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      CCC_IDLE:
        if (start_ok) state_next = CCC_CHARGE; // RL6
      CCC_CHARGE:
        if (!enable || !conv_s) state_next = CCC_IDLE;
        else if (term_ok && ctrl_reg[`CCC_CTRL_TOPOFF_HI:`CCC_CTRL_TOPOFF_LO] != 2'h0)
          state_next = CCC_TOPOFF;
        else if (term_ok) state_next = CCC_DONE;
      CCC_TOPOFF:
        if (!enable || !conv_s) state_next = CCC_IDLE;
        else if (topoff_expire) state_next = CCC_DONE;
      CCC_DONE:
        if (!enable || !conv_s) state_next = CCC_IDLE;
        else if (!above_s && start_ok) state_next = CCC_CHARGE; // RL5
    endcase
  end

  // State register; start, termination, top-off expiry, recharge and loss of an enable or the converter move it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) state_reg <= CCC_IDLE;
    else if (clk_en) state_reg <= state_next;
  end

  // Top-off timer: cleared outside top-off so every entry starts fresh.
  assign topoff_clr = state_reg != CCC_TOPOFF || (wr && paddr == `CCC_OFS_CTRL &&
    pwdata[`CCC_CTRL_RST]); // RL11
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      topoff_min_reg <= 10'h000;
      topoff_sec_reg <= 6'h00;
      half_tick_reg <= 1'b0;
      topoff_dur_reg <= 2'h0;
    end
    else if (clk_en)
    begin
      if (state_reg == CCC_CHARGE && state_next == CCC_TOPOFF)
        topoff_dur_reg <= ctrl_reg[`CCC_CTRL_TOPOFF_HI:`CCC_CTRL_TOPOFF_LO]; // RL12
      if (topoff_clr)
      begin
        topoff_min_reg <= 10'h000;
        topoff_sec_reg <= 6'h00;
        half_tick_reg <= 1'b0;
      end
      else if (tick_s && !pause) // RL10
      begin
        half_tick_reg <= !half_tick_reg;
        if (!half || half_tick_reg)
        begin
          if (topoff_sec_reg == `CCC_TICKS_PER_MIN - 6'h01)
          begin
            topoff_sec_reg <= 6'h00;
            topoff_min_reg <= topoff_min_reg + 10'h001;
          end
          else topoff_sec_reg <= topoff_sec_reg + 6'h01;
        end
      end
    end
  end

  // Control and setting registers; the conversion-off bit is held at one in bypass.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_reg <= `CCC_RST_CTRL; // RL2
      {regulation_voltage_reg, rechg_reg} <= {`CCC_RST_REGULATION_VOLTAGE_MV, `CCC_RST_RECHG_MV};
      {fast_charge_current_reg, termination_current_reg} <= {`CCC_RST_FAST_CHARGE_CURRENT_MA, `CCC_RST_TERMINATION_CURRENT_MA};
      {itrk_reg, ipre_reg} <= {`CCC_RST_ITRK_MA, `CCC_RST_IPRE_MA};
      temp_reg <= `CCC_RST_TEMP;
    end
    else if (clk_en)
    begin
      if (wr && paddr == `CCC_OFS_CTRL && pwdata[`CCC_CTRL_RST])
      begin
        ctrl_reg <= `CCC_RST_CTRL;
        {regulation_voltage_reg, rechg_reg} <= {`CCC_RST_REGULATION_VOLTAGE_MV, `CCC_RST_RECHG_MV};
        {fast_charge_current_reg, termination_current_reg} <= {`CCC_RST_FAST_CHARGE_CURRENT_MA, `CCC_RST_TERMINATION_CURRENT_MA};
        {itrk_reg, ipre_reg} <= {`CCC_RST_ITRK_MA, `CCC_RST_IPRE_MA};
        temp_reg <= `CCC_RST_TEMP;
      end
      else
      begin
        if (wr && paddr == `CCC_OFS_CTRL)
        begin
          ctrl_reg <= pwdata[7:0] & 8'hef;
          if (pwdata[`CCC_CTRL_BYPASS]) ctrl_reg[`CCC_CTRL_CONVOFF] <= 1'b1; // RL15
        end
        else if (ctrl_reg[`CCC_CTRL_BYPASS]) ctrl_reg[`CCC_CTRL_CONVOFF] <= 1'b1; // RL15
        if (wr && paddr == `CCC_OFS_VOLT) {rechg_reg, regulation_voltage_reg} <= pwdata;
        if (wr && paddr == `CCC_OFS_IFAST) {termination_current_reg, fast_charge_current_reg} <= pwdata;
        if (wr && paddr == `CCC_OFS_ILOW) {ipre_reg, itrk_reg} <= pwdata;
        if (wr && paddr == `CCC_OFS_TEMP) temp_reg <= pwdata[13:0];
      end
    end
  end

  // Zone field, per-zone flags and the zone interrupt pulse; set beats read-clear.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      zone_field_reg <= 3'h0;
      zflag_reg <= 8'h00;
      temp_int_pulse <= 1'b0;
    end
    else if (clk_en)
    begin
      zone_field_reg <= znew;
      temp_int_pulse <= 1'b0;
      if (rd && paddr == `CCC_OFS_ZFLAG) zflag_reg <= zflag_reg & ~prdata[7:0];
      if (znew != zone_field_reg && !ctrl_reg[`CCC_CTRL_BYPASS])
      begin
        zflag_reg[znew] <= 1'b1; // RL16
        temp_int_pulse <= !ctrl_reg[`CCC_CTRL_SUPPRESS]; // RL16
      end
    end
  end

  // Charge event flag: set on top-off entry and expiry; a read clears it only if it showed it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn) flag_reg <= 1'b0;
    else if (clk_en)
    begin
      if ((state_reg == CCC_CHARGE && state_next == CCC_TOPOFF) || topoff_expire)
        flag_reg <= 1'b1; // RL13
      else if (rd && paddr == `CCC_OFS_STAT && prdata[6]) flag_reg <= 1'b0;
    end
  end

  // Fold-back current; the C-rate divides only the 20 and 40 percent codes.
  always_comb
  begin
    fold_ma = fast_charge_current_reg;
    unique case ({zcode, temp_reg[9:8]})
      4'h4: fold_ma = fast_charge_current_reg / 16'd5; // RL20
      4'h5: fold_ma = fast_charge_current_reg / 16'd10;
      4'h6: fold_ma = fast_charge_current_reg / 16'd20;
      4'h7: fold_ma = fast_charge_current_reg / 16'd30;
      4'h8: fold_ma = (fast_charge_current_reg << 1) / 16'd5;
      4'h9: fold_ma = fast_charge_current_reg / 16'd5;
      4'ha: fold_ma = fast_charge_current_reg / 16'd10;
      4'hb: fold_ma = fast_charge_current_reg / 16'd15;
      default: fold_ma = (zcode == 2'h0) ? 16'h0000 : fast_charge_current_reg; // RL19
    endcase
    if (ctrl_reg[`CCC_CTRL_BYPASS]) fold_ma = fast_charge_current_reg; // RL14
  end

  // Registered outputs toward the analog side.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      charge_phase_field <= CCC_PH_OFF;
      {charging_active, battery_switch, thermistor_bias_output} <= 3'h2;
      {stat_o, stat_oe, blink_reg, safety_pause, safety_half_rate} <= 5'h00;
      charge_current_ma <= 16'h0000;
      safety_limit_min <= `CCC_TRICKLE_MIN;
    end
    else if (clk_en)
    begin
      if (suspend) charge_phase_field <= CCC_PH_OFF; // RL18
      else if (state_reg == CCC_TOPOFF) charge_phase_field <= CCC_PH_TOP; // RL7
      else if (state_reg == CCC_CHARGE)
        charge_phase_field <= cv_s ? CCC_PH_CV : CCC_PH_CC; // RL7
      else charge_phase_field <= CCC_PH_OFF; // RL7
      charging_active <= (state_reg == CCC_CHARGE || state_reg == CCC_TOPOFF) && !suspend;
      battery_switch <= state_reg != CCC_DONE || supp_s; // RL8
      thermistor_bias_output <= meas_s && !short_s && !ctrl_reg[`CCC_CTRL_BYPASS]; // RL21 RL22
      if (tick_s) blink_reg <= !blink_reg;
      stat_o <= 1'b0;
      stat_oe <= (state_reg == CCC_CHARGE || state_reg == CCC_TOPOFF) &&
        (!suspend || blink_reg); // RL18
      safety_pause <= pause; // RL18
      safety_half_rate <= half && !suspend; // RL17
      charge_current_ma <= (stage_s == 2'h0) ? itrk_reg : (stage_s == 2'h1) ?
        ((zcode == 2'h3) ? ipre_reg :
        16'(32'(fold_ma) * 32'(ipre_reg) / 32'(fast_charge_current_reg | 16'h0001))) : fold_ma;
      safety_limit_min <= (stage_s == 2'h0) ? `CCC_TRICKLE_MIN :
        (stage_s == 2'h1) ? {4'h0, temp_reg[11:10], 4'h0} : {2'h0, temp_reg[13:12], 6'h00}; // RL23
    end
  end

  // APB answer: ready follows setup by one cycle, read data is latched then.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else if (clk_en)
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && (paddr > `CCC_OFS_ZFLAG || paddr[1:0] != 2'h0);
      if (psel && !penable && !pwrite)
      begin
        unique case (paddr)
          `CCC_OFS_CTRL: prdata <= {24'h000000, ctrl_reg};
          `CCC_OFS_VOLT: prdata <= {rechg_reg, regulation_voltage_reg};
          `CCC_OFS_IFAST: prdata <= {termination_current_reg, fast_charge_current_reg};
          `CCC_OFS_ILOW: prdata <= {ipre_reg, itrk_reg};
          `CCC_OFS_TEMP: prdata <= {18'h00000, temp_reg};
          `CCC_OFS_STAT: prdata <= {25'h0000000, flag_reg, state_reg == CCC_DONE,
            zone_field_reg, charge_phase_field};
          `CCC_OFS_ZFLAG: prdata <= {24'h000000, zflag_reg};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_start;
    clk_en && state_reg == CCC_IDLE && start_ok |=> state_reg == CCC_CHARGE;
  endproperty
  a_start: assert property (p_start) else $error("start missed"); // RL3
  property p_noterm;
    clk_en && state_reg == CCC_CHARGE && (iin_s || !ctrl_reg[`CCC_CTRL_TERM]) && enable
      && conv_s |=> state_reg == CCC_CHARGE;
  endproperty
  a_noterm: assert property (p_noterm) else $error("bad termination"); // RL4
  property p_phase;
    clk_en && state_reg == CCC_TOPOFF && !suspend |=> charge_phase_field == CCC_PH_TOP;
  endproperty
  a_phase: assert property (p_phase) else $error("phase wrong"); // RL7
  property p_batsw;
    clk_en && state_reg == CCC_DONE && !supp_s |=> !battery_switch;
  endproperty
  a_batsw: assert property (p_batsw) else $error("switch on when done"); // RL8
  property p_flag;
    clk_en && state_reg == CCC_CHARGE && state_next == CCC_TOPOFF |=> flag_reg;
  endproperty
  a_flag: assert property (p_flag) else $error("flag missing"); // RL13
  property p_bypass;
    clk_en && ctrl_reg[`CCC_CTRL_BYPASS] |-> ctrl_reg[`CCC_CTRL_CONVOFF] ##1
      zone_field_reg == 3'h0;
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass ignored"); // RL14 RL15
  property p_bias;
    clk_en && !meas_s |=> !thermistor_bias_output;
  endproperty
  a_bias: assert property (p_bias) else $error("bias closed idle"); // RL21
  property p_suspend;
    clk_en && suspend |=> charge_phase_field == CCC_PH_OFF && safety_pause;
  endproperty
  a_suspend: assert property (p_suspend) else $error("suspend not shown"); // RL18
  property p_apb;
    psel && !penable && clk_en |=> pready;
  endproperty
  a_apb: assert property (p_apb) else $error("no ready");
  c_topoff: cover property (state_reg == CCC_TOPOFF ##1 state_reg == CCC_DONE);
  c_recharge: cover property (state_reg == CCC_DONE ##1 state_reg == CCC_CHARGE);
  c_zone: cover property (temp_int_pulse);
endmodule

//--- verification/ccc_analog_model.sv
/*
  Analog side of the charger: comparators, regulation loops and timebase.
  Assumes the bench changes its knobs just after a rising edge of pclk.
*/
`timescale 1ns/1ps
module ccc_analog_model (
  // Clock and bench knobs.
  input wire logic pclk,
  input wire logic full,
  input wire logic shorted,
  // Indications toward the controller.
  output logic cv_loop_active,
  output logic vbat_above_rechg,
  output logic ibat_below_term,
  output logic bias_short,
  output logic meas_request,
  output logic tick_1hz
);
  logic [3:0] cnt = 4'h0;
  // A full cell sits in voltage regulation with its current tapered off.
  assign cv_loop_active = full;
  assign vbat_above_rechg = full;
  assign ibat_below_term = full;
  assign bias_short = shorted;
  // Free running phase counter for the timebase.
  always_ff @(posedge pclk)
  begin
    cnt <= cnt + 4'h1;
  end
  // A second is shortened to four clocks so the top-off span stays short.
  assign tick_1hz = (cnt[1:0] == 2'h3);
  // Two clocks of measurement in every sixteen.
  assign meas_request = (cnt[3:1] == 3'h7);
endmodule

//--- verification/test_charge_cycle_controller.sv
/*
  Self-checking bench for the charge cycle controller.
  Assumes ccc_top, its package and the analog model are compiled first.
*/
`timescale 1ns/1ps
`include "ccc_cfg.svh"
module test_charge_cycle_controller;
  import ccc_pkg::*;
  // Bus, pins and knobs.
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, perr;
  logic charge_enable_pin_n = 1'b0;
  logic converter_running = 1'b1;
  logic input_current_loop = 1'b0;
  logic input_voltage_loop = 1'b0;
  logic thermal_loop_active = 1'b0;
  logic safety_fault = 1'b0;
  logic safety_pause_in = 1'b0;
  logic safety_half_in = 1'b0;
  logic supplement_req = 1'b0;
  logic [1:0] battery_stage = 2'h2;
  logic [2:0] zone_in = 3'h0;
  logic full = 1'b0;
  logic shorted = 1'b0;
  logic cv_loop_active, vbat_above_rechg, ibat_below_term, bias_short, meas_request, tick_1hz;
  logic [1:0] charge_phase_field;
  logic charging_active, battery_switch, thermistor_bias_output, stat_o, stat_oe, temp_int_pulse;
  logic safety_pause, safety_half_rate;
  logic [15:0] charge_current_ma;
  logic [9:0] safety_limit_min;
  int errors = 0;
  int n_compared = 0;
  int npulse = 0;

  ccc_top i_dut (
    .pclk, .presetn, .clk_en(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .charge_enable_pin_n, .converter_running, .cv_loop_active, .input_current_loop,
    .input_voltage_loop, .thermal_loop_active, .vbat_above_rechg, .ibat_below_term,
    .zone_in, .bias_short, .meas_request, .safety_fault, .safety_pause_in, .safety_half_in,
    .supplement_req, .battery_stage, .tick_1hz, .charge_phase_field, .charging_active,
    .battery_switch, .thermistor_bias_output, .stat_o, .stat_oe, .temp_int_pulse,
    .safety_pause, .safety_half_rate, .charge_current_ma, .safety_limit_min
  );
  ccc_analog_model i_ana (
    .pclk, .full, .shorted, .cv_loop_active, .vbat_above_rechg, .ibat_below_term, .bias_short,
    .meas_request, .tick_1hz
  );

  // Clock and a count of interrupt pulses.
  always #2 pclk = ~pclk;
  always @(posedge pclk)
  begin
    if (temp_int_pulse === 1'b1)
      npulse++;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // One transfer, then an idle cycle so the next setup never lands in the same step.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rd = prdata;
    perr = pslverr;
    chk(n < 20, 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wph(input logic [1:0] e);
    int n;
    n = 0;
    while (charge_phase_field !== e && n < 8000)
    begin
      @(posedge pclk);
      n++;
    end
    chk(charge_phase_field, e);
  endtask

  task automatic toggle;
    charge_enable_pin_n <= 1'b1;
    cyc(6);
    chk(charge_phase_field, CCC_PH_OFF);
    charge_enable_pin_n <= 1'b0;
  endtask

  task automatic bias_count(input int n, output int nb, output int nm);
    nb = 0;
    nm = 0;
    repeat (n)
    begin
      @(posedge pclk);
      nb += (thermistor_bias_output === 1'b1);
      nm += (meas_request === 1'b1);
    end
  endtask

  task automatic t_regs;
    logic [7:0] a [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
    logic [31:0] e [5] = '{{24'h0, `CCC_RST_CTRL}, {`CCC_RST_RECHG_MV, `CCC_RST_REGULATION_VOLTAGE_MV},
      {`CCC_RST_TERMINATION_CURRENT_MA, `CCC_RST_FAST_CHARGE_CURRENT_MA}, {`CCC_RST_IPRE_MA, `CCC_RST_ITRK_MA},
      {18'h0, `CCC_RST_TEMP}};
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, a[i], 32'h0);
      chk(rd, e[i]);
    end
    apb(1'b0, 8'h1c, 32'h0);
    chk(perr, 1'b1);
    $display("t_regs done");
  endtask

  task automatic t_cycle;
    wph(CCC_PH_CC);
    chk(battery_switch, 1'b1);
    full <= 1'b1;
    input_current_loop <= 1'b1;
    wph(CCC_PH_CV);
    cyc(40);
    chk(charge_phase_field, CCC_PH_CV);
    input_current_loop <= 1'b0;
    input_voltage_loop <= 1'b1;
    cyc(20);
    chk(charge_phase_field, CCC_PH_CV);
    input_voltage_loop <= 1'b0;
    thermal_loop_active <= 1'b1;
    cyc(20);
    chk(charge_phase_field, CCC_PH_CV);
    thermal_loop_active <= 1'b0;
    wph(CCC_PH_OFF);
    cyc(2);
    chk(battery_switch, 1'b0);
    apb(1'b0, `CCC_OFS_STAT, 32'h0);
    chk(rd[5], 1'b1);
    supplement_req <= 1'b1;
    cyc(4);
    chk(battery_switch, 1'b1);
    supplement_req <= 1'b0;
    full <= 1'b0;
    wph(CCC_PH_CC);
    full <= 1'b1;
    wph(CCC_PH_OFF);
    input_current_loop <= 1'b1;
    safety_fault <= 1'b1;
    toggle;
    cyc(20);
    chk(charging_active, 1'b0);
    safety_fault <= 1'b0;
    wph(CCC_PH_CV);
    input_current_loop <= 1'b0;
    wph(CCC_PH_OFF);
    input_current_loop <= 1'b1;
    apb(1'b1, `CCC_OFS_CTRL, 32'h2);
    apb(1'b1, `CCC_OFS_CTRL, 32'h3);
    wph(CCC_PH_CV);
    converter_running <= 1'b0;
    wph(CCC_PH_OFF);
    converter_running <= 1'b1;
    wph(CCC_PH_CV);
    apb(1'b1, `CCC_OFS_CTRL, 32'h1);
    input_current_loop <= 1'b0;
    cyc(60);
    chk(charge_phase_field, CCC_PH_CV);
    $display("t_cycle done");
  endtask

  // Pause holds the timer; half rate doubles the fifteen minute span.
  task automatic t_topoff;
    apb(1'b1, `CCC_OFS_CTRL, 32'h7);
    input_current_loop <= 1'b1;
    toggle;
    wph(CCC_PH_CV);
    apb(1'b0, `CCC_OFS_STAT, 32'h0);
    input_current_loop <= 1'b0;
    wph(CCC_PH_TOP);
    apb(1'b0, `CCC_OFS_STAT, 32'h0);
    chk(rd[6], 1'b1);
    safety_pause_in <= 1'b1;
    apb(1'b1, `CCC_OFS_CTRL, 32'h3);
    cyc(4000);
    chk(charge_phase_field, CCC_PH_TOP);
    safety_pause_in <= 1'b0;
    safety_half_in <= 1'b1;
    cyc(3700);
    chk(charge_phase_field, CCC_PH_TOP);
    wph(CCC_PH_OFF);
    safety_half_in <= 1'b0;
    apb(1'b0, `CCC_OFS_STAT, 32'h0);
    chk(rd[6], 1'b1);
    $display("t_topoff done");
  endtask

  task automatic t_zone;
    logic [15:0] ce [4] = '{16'h0080, 16'h0040, 16'h0020, 16'h0015};
    logic [15:0] we [3] = '{16'h0040, 16'h0020, 16'h0010};
    logic [9:0] lim [3] = '{10'h03c, 10'h020, 10'h040};
    logic v;
    int p;
    input_current_loop <= 1'b1;
    toggle;
    wph(CCC_PH_CV);
    apb(1'b0, `CCC_OFS_ZFLAG, 32'h0);
    for (int r = 0; r < 4; r++)
    begin
      apb(1'b1, `CCC_OFS_TEMP, 32'h0000184b | (32'(r) << 8));
      zone_in <= 3'h4;
      cyc(4);
      chk(charge_current_ma, ce[r]);
      chk(safety_half_rate, 1'b1);
      zone_in <= 3'h1;
      cyc(4);
      if (r < 3)
        chk(charge_current_ma, we[r]);
    end
    for (int s = 0; s < 3; s++)
    begin
      battery_stage <= 2'(s);
      cyc(4);
      chk(safety_limit_min, lim[s]);
    end
    battery_stage <= 2'h2;
    zone_in <= 3'h5;
    cyc(4);
    chk(charge_current_ma, `CCC_RST_FAST_CHARGE_CURRENT_MA);
    chk(safety_half_rate, 1'b0);
    zone_in <= 3'h2;
    wph(CCC_PH_OFF);
    chk(safety_pause, 1'b1);
    v = stat_oe;
    cyc(4);
    chk(stat_oe !== v, 1'b1);
    chk(stat_o, 1'b0);
    apb(1'b0, `CCC_OFS_STAT, 32'h0);
    chk(rd[4:0], 5'h08);
    p = npulse;
    zone_in <= 3'h0;
    wph(CCC_PH_CV);
    cyc(2);
    chk(npulse, p + 1);
    apb(1'b0, `CCC_OFS_ZFLAG, 32'h0);
    chk(rd[7:0], 8'h37);
    apb(1'b1, `CCC_OFS_CTRL, 32'h23);
    zone_in <= 3'h6;
    cyc(6);
    apb(1'b0, `CCC_OFS_CTRL, 32'h0);
    chk(rd, 32'h63);
    apb(1'b0, `CCC_OFS_STAT, 32'h0);
    chk(rd[4:0], {3'h0, CCC_PH_CV});
    apb(1'b1, `CCC_OFS_CTRL, 32'h3);
    wph(CCC_PH_OFF);
    zone_in <= 3'h0;
    apb(1'b1, `CCC_OFS_CTRL, 32'h13);
    apb(1'b0, `CCC_OFS_TEMP, 32'h0);
    chk(rd, {18'h0, `CCC_RST_TEMP});
    wph(CCC_PH_CV);
    $display("t_zone done");
  endtask

  task automatic t_short;
    int nb;
    int nm;
    int p;
    bias_count(64, nb, nm);
    chk(nb, nm);
    apb(1'b1, `CCC_OFS_CTRL, 32'h83);
    p = npulse;
    shorted <= 1'b1;
    wph(CCC_PH_OFF);
    bias_count(32, nb, nm);
    chk(nb, 0);
    chk(npulse, p);
    apb(1'b0, `CCC_OFS_STAT, 32'h0);
    chk(rd[4:2], 3'h3);
    shorted <= 1'b0;
    wph(CCC_PH_CV);
    $display("t_short done");
  endtask

  task automatic wrap_up;
    $display("compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // Main sequence after a twelve cycle reset.
  initial
  begin
    cyc(12);
    presetn <= 1'b1;
    t_regs;
    t_cycle;
    t_topoff;
    t_zone;
    t_short;
    wrap_up;
  end

  // The tests need about 12000 cycles; this limit allows about eight times that.
  initial
  begin
    #400000;
    errors++;
    $display("[ERR] %0t watchdog expired", $time);
    wrap_up;
  end
endmodule
